//--- logic/asr_pkg.sv
`default_nettype none
package asr_pkg;
    // Memory shape
    localparam int ADDR_W = 16;
    localparam int DATA_W = 4;

    // Clock period in ns
    localparam int CLK_PERIOD_NS = 10;

    // Pin timing in ns, slowest speed grade
    localparam int READ_CYCLE_MINIMUM_NS      = 55;
    localparam int ADDRESS_ACCESS_DELAY_NS    = 55;
    localparam int SELECT_ACCESS_DELAY_NS     = 55;
    localparam int DESELECT_TO_FLOAT_DELAY_NS = 20;
    localparam int ADDRESS_TO_WRITE_END_NS    = 50;
    localparam int ADDRESS_HOLD_TIME_NS       = 2;
    localparam int STROBE_TO_FLOAT_DELAY_NS   = 20;
    localparam int DATA_SETUP_NS              = 20;

    // Least times round up to whole cycles
    localparam int ACCESS_CYC_I  = (((SELECT_ACCESS_DELAY_NS > ADDRESS_ACCESS_DELAY_NS) ?
                                     SELECT_ACCESS_DELAY_NS : ADDRESS_ACCESS_DELAY_NS)
                                    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_CYC_I   = (DESELECT_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_FLT_I  = (STROBE_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC_I   = (ADDRESS_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC_I   = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC_I    = (ADDRESS_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYC_I = (READ_CYCLE_MINIMUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0] ACCESS_CYC   = 4'(ACCESS_CYC_I);
    localparam logic [3:0] FLOAT_CYC    = 4'(FLOAT_CYC_I);
    localparam logic [3:0] STROBE_FLT   = 4'(STROBE_FLT_I);
    // Pulse long enough for both the address window and data setup after the float
    localparam logic [3:0] PULSE_CYC    = 4'((PULSE_CYC_I > STROBE_FLT_I + SETUP_CYC_I) ?
                                             PULSE_CYC_I : STROBE_FLT_I + SETUP_CYC_I);
    localparam logic [3:0] HOLD_CYC     = 4'(HOLD_CYC_I);
    localparam logic [3:0] RECOVERY_CYC = 4'(RECOVERY_CYC_I);

    // Reset values of the pins
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [3:0]  DATA_RESET = 4'h0;

    typedef enum logic [2:0] {
        ASR_IDLE    = 3'b000,
        ASR_RD_WAIT = 3'b001,
        ASR_RD_OPEN = 3'b010,
        ASR_WR_PULS = 3'b011,
        ASR_WR_HOLD = 3'b100,
        ASR_FLOAT   = 3'b101,
        ASR_RETAIN  = 3'b110,
        ASR_RECOVER = 3'b111
    } asr_state_t;
endpackage
`default_nettype wire

//--- logic/asr_host.sv
// Overview of operation
// - Host holds select low at least 20 to 50 ns before write end.
// - Host keeps the address valid 20 to 50 ns before write end.
// - Address set by write start and held 2 ns after write end.
// - Host keeps strobe high throughout every read.
// - Address-controlled read: select stays low, data follows address changes.
// - Select-controlled read: address valid no later than select fall.
// - Host deselects before retention and stays deselected throughout.
`timescale 1ns/1ps
`default_nettype none
module asr_host
    import asr_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      nrst,
    input  wire logic                      req_valid,
    input  wire logic                      req_write,
    input  wire logic [asr_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [asr_pkg::DATA_W-1:0] req_wdata,
    output var  logic                      req_ready,
    output var  logic                      rsp_valid,
    output var  logic [asr_pkg::DATA_W-1:0] rsp_rdata,
    input  wire logic                      retention_req,
    output var  logic                      retention_active,
    output var  logic [asr_pkg::ADDR_W-1:0] mem_addr,
    output var  logic                      chip_select_n,
    output var  logic                      write_strobe_n,
    input  wire logic [asr_pkg::DATA_W-1:0] data_in,
    output var  logic [asr_pkg::DATA_W-1:0] data_out,
    output var  logic                      data_oe
);
    import asr_pkg::*;

    asr_state_t              state;
    asr_state_t              next_state;
    logic [3:0]              cnt;
    logic [3:0]              next_cnt;
    logic                    next_req_ready;
    logic                    next_rsp_valid;
    logic [DATA_W-1:0]       next_rsp_rdata;
    logic                    next_retention_active;
    logic [ADDR_W-1:0]       next_mem_addr;
    logic                    next_chip_select_n;
    logic                    next_write_strobe_n;
    logic [DATA_W-1:0]       next_data_out;
    logic                    next_data_oe;
    logic                    take;

    assign take = req_valid && req_ready;

    // Sequencer: every pin edge is placed by the cycle counter, so the timing
    // is met by construction rather than by the caller's pacing
    always_comb begin
        next_state            = state;
        next_cnt              = (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
        next_req_ready        = 1'b0;
        next_rsp_valid        = 1'b0;
        next_rsp_rdata        = rsp_rdata;
        next_retention_active = retention_active;
        next_mem_addr         = mem_addr;
        next_chip_select_n    = chip_select_n;
        next_write_strobe_n   = 1'b1;
        next_data_out         = data_out;
        next_data_oe          = 1'b0;
        unique case (state)
            ASR_IDLE: begin
                // A taken request is served first, so a late retention request never drops it
                if (take && req_write) begin
                    // Address, select and strobe move together: zero setup is allowed
                    next_mem_addr       = req_addr;
                    next_data_out       = req_wdata;
                    next_chip_select_n  = 1'b0;
                    next_write_strobe_n = 1'b0;
                    next_cnt            = PULSE_CYC - 4'h1;
                    next_state          = ASR_WR_PULS;
                end else if (take) begin
                    // Address goes out in the same edge as select falls
                    next_mem_addr      = req_addr;
                    next_chip_select_n = 1'b0;
                    next_cnt           = ACCESS_CYC - 4'h1;
                    next_state         = ASR_RD_WAIT;
                end else if (retention_req) begin
                    // Select is already high here, so retention never starts selected
                    next_state            = ASR_RETAIN;
                    next_retention_active = 1'b1;
                end else begin
                    next_req_ready = 1'b1;
                end
            end
            ASR_RD_WAIT: begin
                // Sample only after the full access time has passed
                if (cnt == 4'h0) begin
                    next_rsp_valid = 1'b1;
                    next_rsp_rdata = data_in;
                    next_state     = ASR_RD_OPEN;
                    next_req_ready = !retention_req;
                end
            end
            ASR_RD_OPEN: begin
                if (take && req_write) begin
                    // Select stays low and the strobe falls; the data drive waits for the float
                    next_mem_addr       = req_addr;
                    next_data_out       = req_wdata;
                    next_write_strobe_n = 1'b0;
                    next_cnt            = PULSE_CYC - 4'h1;
                    next_state          = ASR_WR_PULS;
                end else if (take) begin
                    // Select stays low, only the address moves; a taken read is never dropped
                    next_mem_addr = req_addr;
                    next_cnt      = ACCESS_CYC - 4'h1;
                    next_state    = ASR_RD_WAIT;
                end else begin
                    // Nothing offered in the open cycle: deselect and turn the bus round
                    next_chip_select_n = 1'b1;
                    next_cnt           = FLOAT_CYC - 4'h1;
                    next_state         = ASR_FLOAT;
                end
            end
            ASR_WR_PULS: begin
                next_chip_select_n  = 1'b0;
                next_write_strobe_n = 1'b0;
                // Drive only once the memory has surely released the bus
                next_data_oe = (PULSE_CYC - cnt) >= STROBE_FLT;
                if (cnt == 4'h0) begin
                    // Select and address held the whole pulse before the end
                    next_chip_select_n  = 1'b1;
                    next_write_strobe_n = 1'b1;
                    next_data_oe        = 1'b1;
                    next_cnt            = HOLD_CYC - 4'h1;
                    next_state          = ASR_WR_HOLD;
                end
            end
            ASR_WR_HOLD: begin
                // Address and data stay put past the write end
                next_data_oe = 1'b1;
                if (cnt == 4'h0) begin
                    next_data_oe = 1'b0;
                    next_cnt     = FLOAT_CYC - 4'h1;
                    next_state   = ASR_FLOAT;
                end
            end
            ASR_FLOAT: begin
                // Bus turnaround: no host drive until the memory has floated
                if (cnt == 4'h0) begin
                    next_state     = ASR_IDLE;
                    next_req_ready = !retention_req;
                end
            end
            ASR_RETAIN: begin
                next_chip_select_n = 1'b1;
                if (!retention_req) begin
                    next_retention_active = 1'b0;
                    next_cnt              = RECOVERY_CYC - 4'h1;
                    next_state            = ASR_RECOVER;
                end
            end
            ASR_RECOVER: begin
                // One full read cycle before the first access after retention
                if (cnt == 4'h0) begin
                    next_state     = ASR_IDLE;
                    next_req_ready = !retention_req;
                end
            end
        endcase
    end

    // All pins and user outputs come straight from these flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state            <= ASR_IDLE;
            cnt              <= 4'h0;
            req_ready        <= 1'b0;
            rsp_valid        <= 1'b0;
            rsp_rdata        <= DATA_RESET;
            retention_active <= 1'b0;
            mem_addr         <= ADDR_RESET;
            chip_select_n    <= 1'b1; // Deselected, so the memory floats in reset
            write_strobe_n   <= 1'b1;
            data_out         <= DATA_RESET;
            data_oe          <= 1'b0;
        end else begin
            state            <= next_state;
            cnt              <= next_cnt;
            req_ready        <= next_req_ready;
            rsp_valid        <= next_rsp_valid;
            rsp_rdata        <= next_rsp_rdata;
            retention_active <= next_retention_active;
            mem_addr         <= next_mem_addr;
            chip_select_n    <= next_chip_select_n;
            write_strobe_n   <= next_write_strobe_n;
            data_out         <= next_data_out;
            data_oe          <= next_data_oe;
        end
    end
endmodule
`default_nettype wire

//--- bench/asr_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model
    import asr_pkg::*;
(
    input  wire logic                       chip_select_n,
    input  wire logic                       write_strobe_n,
    input  wire logic [asr_pkg::ADDR_W-1:0] mem_addr,
    input  wire logic [asr_pkg::DATA_W-1:0] data_out,
    input  wire logic                       data_oe,
    output var  logic [asr_pkg::DATA_W-1:0] data_in
);
    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
    logic              settled = 1'b0;
    logic              in_write = 1'b0;
    int                gen = 0;
    // Valid flag lingers 5 ns, so the new address reads at once; then junk until full access time
    always @(chip_select_n, write_strobe_n, mem_addr) begin
        gen = gen + 1;
        settled <= #5 1'b0;
        fork
            begin : settle
                automatic int g = gen;
                #(SELECT_ACCESS_DELAY_NS);
                if (g == gen) settled = 1'b1;
            end
        join_none
    end
    // Word lands when the low-low overlap ends; standby when deselected
    always @(chip_select_n, write_strobe_n) begin
        if (!chip_select_n && !write_strobe_n) in_write = 1'b1;
        else if (in_write) begin
            cells[mem_addr] = data_in;
            in_write = 1'b0;
        end
    end
    // No pull on the bus: a floating line reads as the inverted word
    assign data_in = data_oe ? data_out : (!chip_select_n && write_strobe_n && settled) ?
                     cells[mem_addr] : ~cells[mem_addr];
endmodule
`default_nettype wire

//--- bench/asr_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module asr_host_asserts (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    input wire logic        retention_active,
    input wire logic [15:0] mem_addr,
    input wire logic        chip_select_n,
    input wire logic        write_strobe_n,
    input wire logic        data_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_pulse;
        !write_strobe_n [*5];
    endsequence
    sequence s_access;
        !rsp_valid [*6] ##1 rsp_valid;
    endsequence
    strobe_needs_sel_a: assert property (!write_strobe_n |-> !chip_select_n)
        else $error("strobe low while deselected");
    pulse_width_a: assert property ($fell(write_strobe_n) |-> s_pulse)
        else $error("write pulse too short");
    addr_in_write_a: assert property ($fell(write_strobe_n) |=> $stable(mem_addr) [*4])
        else $error("address moved during write");
    addr_hold_a: assert property ($rose(write_strobe_n) |-> $stable(mem_addr))
        else $error("address moved at write end");
    read_strobe_a: assert property ($fell(chip_select_n) && write_strobe_n |-> write_strobe_n [*7])
        else $error("strobe fell during read");
    float_wait_a: assert property ($fell(write_strobe_n) |-> !data_oe ##1 !data_oe)
        else $error("host drove before memory floated");
    oe_window_a: assert property (data_oe |-> !write_strobe_n || $past(!write_strobe_n))
        else $error("host drove outside write");
    retain_quiet_a: assert property (retention_active |-> chip_select_n && !data_oe)
        else $error("access during retention");
    recover_gap_a: assert property ($fell(retention_active) |-> chip_select_n [*6])
        else $error("access too soon after retention");
    read_latency_a: assert property (req_valid && req_ready && !req_write |=> s_access)
        else $error("read answer late or early");
endmodule
bind asr_host asr_host_asserts u_chk (.mclk, .nrst, .req_valid, .req_write, .req_ready, .rsp_valid,
    .retention_active, .mem_addr, .chip_select_n, .write_strobe_n, .data_oe);
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import asr_pkg::*;
    logic              mclk, nrst, req_valid, req_write, retention_req;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata;
    wire logic         req_ready, rsp_valid, retention_active, chip_select_n, write_strobe_n, data_oe;
    wire logic [15:0]  mem_addr;
    wire logic [3:0]   rsp_rdata, data_in, data_out;
    wire logic [2:0]   flags = {retention_active, rsp_valid, req_ready};
    int                bad_count = 0;
    int                n_tests = 0;
    int                n;
    asr_host dut (.mclk, .nrst, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready, .rsp_valid,
        .rsp_rdata, .retention_req, .retention_active, .mem_addr, .chip_select_n, .write_strobe_n,
        .data_in, .data_out, .data_oe);
    asr_sram_model mem (.chip_select_n, .write_strobe_n, .mem_addr, .data_out, .data_oe, .data_in);
    task automatic close_out;
        $display("mismatches %0d of %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait on falling edges; a hang counts as a mismatch
    task automatic wait_for(input int sel, output int cnt);
        cnt = 0;
        do begin
            @(negedge mclk);
            cnt++;
        end while (flags[sel] !== 1'b1 && cnt < 40);
        if (flags[sel] !== 1'b1) begin
            bad_count++;
            close_out();
        end
    endtask
    task automatic issue(input logic w, input logic [15:0] a, input logic [3:0] d);
        int k;
        wait_for(0, k);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(negedge mclk);
        req_valid = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [3:0] exp);
        int k;
        issue(1'b0, a, 4'h0);
        wait_for(1, k);
        check("read word", rsp_rdata, exp);
        check("read latency", 16'(k), 16'h0006);
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {nrst, req_valid, req_write, retention_req, req_addr, req_wdata} = '0;
        repeat (6) @(negedge mclk);
        check("idle pins", {chip_select_n, write_strobe_n, data_oe, req_ready}, 16'h000c);
        nrst = 1'b1;
        // Neighbouring and extreme addresses, written first and read back after
        issue(1'b1, 16'h0000, 4'hc);
        issue(1'b1, 16'hffff, 4'h3);
        issue(1'b1, 16'h5a5a, 4'h9);
        issue(1'b1, 16'h5a5b, 4'h6);
        rd(16'h0000, 4'hc);
        rd(16'h5a5b, 4'h6);
        // Chained read keeps select low across the address change
        issue(1'b0, 16'hffff, 4'h0);
        wait_for(1, n);
        check("chain word", rsp_rdata, 4'h3);
        check("chain ready", req_ready, 1'b1);
        req_valid = 1'b1;
        req_addr = 16'h5a5a;
        @(negedge mclk);
        req_valid = 1'b0;
        check("chain select", chip_select_n, 1'b0);
        wait_for(1, n);
        check("chain second", rsp_rdata, 4'h9);
        // A write offered in the open cycle starts with select still low
        req_valid = 1'b1;
        req_write = 1'b1;
        req_addr = 16'h1234;
        req_wdata = 4'ha;
        @(negedge mclk);
        req_valid = 1'b0;
        req_write = 1'b0;
        check("chain strobe", {chip_select_n, write_strobe_n}, 16'h0000);
        rd(16'h1234, 4'ha);
        // Retention refuses work and recovers only after a full read cycle
        retention_req = 1'b1;
        wait_for(2, n);
        repeat (3) @(negedge mclk);
        check("retain select", {chip_select_n, req_ready}, 2'b10);
        retention_req = 1'b0;
        wait_for(0, n);
        check("recovery gap", 16'(n >= 6), 16'h0001);
        rd(16'hffff, 4'h3);
        close_out();
    end
endmodule
`default_nettype wire
